//--- ppcb_pkg.sv
// Package of constants for the port pad control bank
`default_nettype none

package ppcb_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int unsigned PIN_COUNT  = 5;
	localparam int unsigned REG_WIDTH  = 8;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned ADDR_WIDTH = 12;
	localparam int unsigned REG_COUNT  = 4;
	localparam int unsigned IDX_WIDTH  = 2;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_WIDTH-1:0] OFS_PULL_ENABLE    = 12'h000;
	localparam logic [ADDR_WIDTH-1:0] OFS_PULL_POLARITY  = 12'h004;
	localparam logic [ADDR_WIDTH-1:0] OFS_SLEW_LIMIT     = 12'h008;
	localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE_STRENGTH = 12'h00C;

	// Register indices inside the storage array
	localparam logic [IDX_WIDTH-1:0] IDX_PULL_ENABLE    = 2'h0;
	localparam logic [IDX_WIDTH-1:0] IDX_PULL_POLARITY  = 2'h1;
	localparam logic [IDX_WIDTH-1:0] IDX_SLEW_LIMIT     = 2'h2;
	localparam logic [IDX_WIDTH-1:0] IDX_DRIVE_STRENGTH = 2'h3;

	// ----------------------------------------
	// Reset values and encodings
	// ----------------------------------------
	localparam logic [PIN_COUNT-1:0]  PAD_RESET     = 5'h00;
	localparam logic [DATA_WIDTH-1:0] READ_ZERO     = 32'h0000_0000;
	localparam logic                  POL_PULLUP    = 1'b0;
	localparam logic                  DIR_OUTPUT    = 1'b1;

endpackage : ppcb_pkg

`default_nettype wire

//--- ppcb_reg_if.sv
// Interface carrying the register write port and stored values
`timescale 1ns/100ps
`default_nettype none

interface ppcb_reg_if;
	logic                                      wr_en;
	logic [ppcb_pkg::IDX_WIDTH-1:0]            wr_idx;
	logic [ppcb_pkg::PIN_COUNT-1:0]            wr_data;
	logic [ppcb_pkg::PIN_COUNT-1:0]            pull_enable_bits;
	logic [ppcb_pkg::PIN_COUNT-1:0]            pull_polarity_bits;
	logic [ppcb_pkg::PIN_COUNT-1:0]            slew_limit_bits;
	logic [ppcb_pkg::PIN_COUNT-1:0]            drive_strength_bits;

	modport ctrl (
		output wr_en,
		output wr_idx,
		output wr_data,
		input  pull_enable_bits,
		input  pull_polarity_bits,
		input  slew_limit_bits,
		input  drive_strength_bits
	);

	modport store (
		input  wr_en,
		input  wr_idx,
		input  wr_data,
		output pull_enable_bits,
		output pull_polarity_bits,
		output slew_limit_bits,
		output drive_strength_bits
	);
endinterface : ppcb_reg_if

`default_nettype wire

//--- ppcb_reg_store.sv
// Storage for the four pad control registers
`timescale 1ns/100ps
`default_nettype none

module ppcb_reg_store (
	input  wire logic   pclk,
	input  wire logic   presetn,
	ppcb_reg_if.store   rif
);

	logic [ppcb_pkg::PIN_COUNT-1:0] regs_q [ppcb_pkg::REG_COUNT];

	// ----------------------------------------
	// Register array
	// ----------------------------------------
	// Held apart from the data and direction registers
	genvar gi;
	generate
		for (gi = 0; gi < ppcb_pkg::REG_COUNT; gi++) begin : g_reg
			// Slot index cut to the write-index width on purpose
			localparam logic [ppcb_pkg::IDX_WIDTH-1:0] SLOT = ppcb_pkg::IDX_WIDTH'(gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					regs_q[gi] <= ppcb_pkg::PAD_RESET;
				end else if (rif.wr_en && rif.wr_idx == SLOT) begin
					regs_q[gi] <= rif.wr_data;
				end
			end
		end
	endgenerate

	assign rif.pull_enable_bits    = regs_q[ppcb_pkg::IDX_PULL_ENABLE];
	assign rif.pull_polarity_bits  = regs_q[ppcb_pkg::IDX_PULL_POLARITY];
	assign rif.slew_limit_bits     = regs_q[ppcb_pkg::IDX_SLEW_LIMIT];
	assign rif.drive_strength_bits = regs_q[ppcb_pkg::IDX_DRIVE_STRENGTH];

endmodule // ppcb_reg_store

`default_nettype wire

//--- ppcb_top.sv
// Pad control bank for one five-pin port, APB slave
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// R1 - One pull-enable bit per pin
// R2 - Outputs force the pull device off
// R3 - Analog ownership forces pull off
// R4 - Polarity bit: 0 pullup, 1 pulldown
// R5 - Polarity alone never turns pull on
// R6 - Five slew-limit bits, one per pin
// R7 - Slew limit ignored on input pins
// R8 - Five drive-strength bits, set means high
// R9 - Pad bits kept apart from data/direction
// R10 - Direction bit 1 means output pin
// R11 - Reset clears all bits; readback works
module ppcb_top (
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [ppcb_pkg::ADDR_WIDTH-1:0]    paddr,
	input  wire logic [ppcb_pkg::DATA_WIDTH-1:0]    pwdata,
	output logic      [ppcb_pkg::DATA_WIDTH-1:0]    prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic [ppcb_pkg::PIN_COUNT-1:0]     pin_direction_bits,
	input  wire logic [ppcb_pkg::PIN_COUNT-1:0]     periph_output_en,
	input  wire logic [ppcb_pkg::PIN_COUNT-1:0]     analog_owned,
	output logic      [ppcb_pkg::PIN_COUNT-1:0]     pullup_on,
	output logic      [ppcb_pkg::PIN_COUNT-1:0]     pulldown_on,
	output logic      [ppcb_pkg::PIN_COUNT-1:0]     slew_limit_on,
	output logic      [ppcb_pkg::PIN_COUNT-1:0]     high_drive_on
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic addr_hit(input logic [ppcb_pkg::ADDR_WIDTH-1:0] a,
	                                  output logic [ppcb_pkg::IDX_WIDTH-1:0] idx);
		addr_hit = 1'b1;
		idx      = ppcb_pkg::IDX_PULL_ENABLE;
		unique case (a)
			ppcb_pkg::OFS_PULL_ENABLE:    idx = ppcb_pkg::IDX_PULL_ENABLE;
			ppcb_pkg::OFS_PULL_POLARITY:  idx = ppcb_pkg::IDX_PULL_POLARITY;
			ppcb_pkg::OFS_SLEW_LIMIT:     idx = ppcb_pkg::IDX_SLEW_LIMIT;
			ppcb_pkg::OFS_DRIVE_STRENGTH: idx = ppcb_pkg::IDX_DRIVE_STRENGTH;
			default:                      addr_hit = 1'b0;
		endcase
	endfunction

	ppcb_reg_if rif ();

	logic                              hit;
	logic [ppcb_pkg::IDX_WIDTH-1:0]    idx;
	logic                              access;
	logic [ppcb_pkg::PIN_COUNT-1:0]    rd_sel;
	logic [ppcb_pkg::PIN_COUNT-1:0]    is_output;
	logic [ppcb_pkg::PIN_COUNT-1:0]    pull_allowed;
	logic [ppcb_pkg::PIN_COUNT-1:0]    pull_active;

	always_comb begin
		hit = addr_hit(paddr, idx);
	end

	// Zero-wait slave: the access phase finishes in one cycle
	assign access = psel & penable;

	// ----------------------------------------
	// Register write path
	// ----------------------------------------
	// R1 - writable pull enable
	// Only the low five bits are stored; upper data bits are dropped
	assign rif.wr_en   = access & pwrite & hit;
	assign rif.wr_idx  = idx;
	assign rif.wr_data = pwdata[ppcb_pkg::PIN_COUNT-1:0];

	// R9 - separate storage
	ppcb_reg_store u_store (
		.pclk    (pclk),
		.presetn (presetn),
		.rif     (rif)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// R11 - readback of last write
	assign rd_sel = (idx == ppcb_pkg::IDX_PULL_ENABLE)   ? rif.pull_enable_bits   :
	                (idx == ppcb_pkg::IDX_PULL_POLARITY) ? rif.pull_polarity_bits :
	                (idx == ppcb_pkg::IDX_SLEW_LIMIT)    ? rif.slew_limit_bits    :
	                                                       rif.drive_strength_bits;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= ppcb_pkg::READ_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			if (psel && !penable && !pwrite && hit) begin
				prdata <= {{(ppcb_pkg::DATA_WIDTH-ppcb_pkg::PIN_COUNT){1'b0}}, rd_sel};
			end else if (access) begin
				prdata <= ppcb_pkg::READ_ZERO;
			end
		end
	end

	// ----------------------------------------
	// Pad gating
	// ----------------------------------------
	// R10 - direction one is output
	assign is_output = pin_direction_bits | periph_output_en;

	// R2 - outputs kill pull
	// R3 - analog kills pull
	assign pull_allowed = ~is_output & ~analog_owned;

	// R5 - polarity needs enable
	assign pull_active = rif.pull_enable_bits & pull_allowed;

	// Slew only meaningful on a driven pin, so registered gated by pin_direction_bits alone, not by the pull gating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_on     <= ppcb_pkg::PAD_RESET;
			pulldown_on   <= ppcb_pkg::PAD_RESET;
			slew_limit_on <= ppcb_pkg::PAD_RESET;
			high_drive_on <= ppcb_pkg::PAD_RESET;
		end else begin
			// R4 - polarity chooses device
			pullup_on     <= pull_active & ~rif.pull_polarity_bits;
			pulldown_on   <= pull_active & rif.pull_polarity_bits;
			// R6 - slew per pin
			// R7 - inputs ignore slew
			slew_limit_on <= rif.slew_limit_bits & pin_direction_bits;
			// R8 - high drive per pin
			high_drive_on <= rif.drive_strength_bits & pin_direction_bits;
		end
	end

endmodule // ppcb_top

`default_nettype wire

//--- ppcb_sva.sv
// Checker of the pad control bank ports
`timescale 1ns/100ps
`default_nettype none
module ppcb_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic [4:0]  pin_direction_bits,
	input wire logic [4:0]  periph_output_en,
	input wire logic [4:0]  analog_owned,
	input wire logic [4:0]  pullup_on,
	input wire logic [4:0]  pulldown_on,
	input wire logic [4:0]  slew_limit_on,
	input wire logic [4:0]  high_drive_on
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pull_out_off: assert property (
		((pullup_on | pulldown_on) & $past(pin_direction_bits | periph_output_en)) == 5'h00)
		else $error("pull on at output pin");
	a_pull_analog_off: assert property (
		((pullup_on | pulldown_on) & $past(analog_owned)) == 5'h00) else $error("pull on at analog");
	a_pull_one_side: assert property (
		(pullup_on & pulldown_on) == 5'h00) else $error("both pulls on");
	a_slew_input_off: assert property (
		(slew_limit_on & ~$past(pin_direction_bits)) == 5'h00) else $error("slew on input");
	a_drive_input_off: assert property (
		(high_drive_on & ~$past(pin_direction_bits)) == 5'h00) else $error("drive on input");
	a_ready_setup: assert property (
		psel && !penable |=> pready) else $error("no answer to setup");
	a_ready_pulse: assert property (
		pready |-> $past(psel && !penable) ##1 !pready) else $error("ready not one pulse");
	a_err_ready: assert property (
		pslverr |-> pready) else $error("error without ready");
	a_rdata_idle: assert property (
		!pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
endmodule // ppcb_chk
bind ppcb_top ppcb_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
	.pin_direction_bits, .periph_output_en, .analog_owned, .pullup_on, .pulldown_on,
	.slew_limit_on, .high_drive_on);
`default_nettype wire

//--- ppcb_pad_model.sv
// Pad level model seen at the pins
`timescale 1ns/100ps
`default_nettype none
module ppcb_pad_model (
	input wire logic       pclk,
	input wire logic [4:0] up,
	input wire logic [4:0] dn,
	output logic     [4:0] pad
);
	// Floating pins toggle so no stale level passes for a pull
	logic [4:0] tog_q = 5'h15;
	always_ff @(posedge pclk) begin
		tog_q <= ~tog_q;
	end
	assign pad = up | (~dn & tog_q);
endmodule // ppcb_pad_model
`default_nettype wire

//--- tb.sv
// Testbench of the pad control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
	$display("unexpected %s expected %h seen %h", n, e, s); end end
module tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
	logic        pready, pslverr, ev;
	logic [4:0]  dir = 5'h00, per = 5'h00, ana = 5'h00, up, dn, sl, hd, pad;
	int          err_total = 0, n_compared = 0;
	typedef struct {logic [4:0] r [4]; logic [4:0] d, p, a, u, n, s, h;} ppcb_row_s;
	ppcb_row_s rows [4] = '{
		'{'{5'h1F, 5'h0A, 5'h15, 5'h0F}, 5'h03, 5'h04, 5'h08, 5'h10, 5'h00, 5'h01, 5'h03},
		'{'{5'h0E, 5'h1B, 5'h1F, 5'h10}, 5'h10, 5'h00, 5'h00, 5'h04, 5'h0A, 5'h10, 5'h10},
		'{'{5'h00, 5'h1F, 5'h00, 5'h1F}, 5'h1F, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1F},
		'{'{5'h1F, 5'h00, 5'h1F, 5'h00}, 5'h00, 5'h00, 5'h00, 5'h1F, 5'h00, 5'h00, 5'h00}};
	always #12.5 pclk = ~pclk;
	ppcb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pin_direction_bits(dir), .periph_output_en(per),
		.analog_owned(ana), .pullup_on(up), .pulldown_on(dn), .slew_limit_on(sl),
		.high_drive_on(hd));
	ppcb_pad_model u_pad (.pclk, .up, .dn, .pad);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Read at the rising edge itself; the design's update there lands after this read
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge pclk);
		err_total++;
		results();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			apb(1'b0, 12'(4 * j), 32'h0);
			`CHK("reset reg", 32'h0000_0000, rv)
			`CHK("mapped err", 1'b0, ev)
		end
		`CHK("reset pads", 20'h00000, {up, dn, sl, hd})
		$display("test reset done");
		foreach (rows[i]) begin
			for (int j = 0; j < 4; j++) apb(1'b1, 12'(4 * j), {27'h0, rows[i].r[j]});
			dir <= rows[i].d; per <= rows[i].p; ana <= rows[i].a;
			for (int j = 0; j < 4; j++) begin
				apb(1'b0, 12'(4 * j), 32'h0);
				`CHK("readback", {27'h0, rows[i].r[j]}, rv)
			end
			@(negedge pclk);
			`CHK("pullup", rows[i].u, up)
			`CHK("pulldown", rows[i].n, dn)
			`CHK("slew", rows[i].s, sl)
			`CHK("drive", rows[i].h, hd)
			`CHK("pad", rows[i].u, pad & (up | dn))
			$display("test row %0d done", i);
		end
		apb(1'b1, 12'h000, 32'hFFFF_FFFF);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("wide write", 32'h0000_001F, rv)
		apb(1'b1, 12'h010, 32'h0000_001F);
		`CHK("unmapped err", 1'b1, ev)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped read", 32'h0000_0000, rv)
		$display("test unmapped done");
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK("mid reset pads", 20'h00000, {up, dn, sl, hd})
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`CHK("mid reset reg", 32'h0000_0000, rv)
		$display("test mid reset done");
		results();
	end
endmodule // tb
`default_nettype wire
